// [inc/sspb_params.svh]
/*
  register offsets, field positions, reset values and codes for the
  switch status and power budget register group.
  assumes inclusion by bare name from design files.
*/
`ifndef SSPB_PARAMS_SVH
`define SSPB_PARAMS_SVH

`define SSPB_ADDR_W          12
`define SSPB_OFF_BUDGET_BASE 12'h300
`define SSPB_OFF_SEL         12'h284
`define SSPB_OFF_BUDGET_DATA 12'h288
`define SSPB_OFF_STATUS      12'h328
`define SSPB_OFF_CONTROL     12'h32C
`define SSPB_NUM_WORDS       10
`define SSPB_SEL_MAX         8'h09
`define SSPB_MODE_LSB        0
`define SSPB_CCLK_DS_BIT     5
`define SSPB_CCLK_US_BIT     6
`define SSPB_HOLD_BIT        9
`define SSPB_LOCK_LSB        20
`define SSPB_MARKER_LSB      28
`define SSPB_CTL_UNLOCK_BIT  3
`define SSPB_CTL_BUDGET_BIT  4
`define SSPB_MARKER_RST      4'h0
`define SSPB_LOCK_RST        3'h0

`endif

// [inc/sspb_pkg.sv]
/*
  types for the switch status and power budget register group.
  assumes the params header is available on the include path.
*/
package sspb_pkg;

  // register port request as one bundle
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sspb_req_type;

  // strap levels captured at fundamental reset
  typedef struct packed {
    logic [2:0] mode;
    logic       cclk_ds;
    logic       cclk_us;
    logic       hold;
  } sspb_strap_type;

  // upstream lock state codes
  typedef enum logic [2:0] {
    SSPB_UNLOCKED = 3'h0,
    SSPB_LOCK_P2  = 3'h2,
    SSPB_LOCK_P3  = 3'h3,
    SSPB_LOCK_P4  = 3'h4
  } sspb_lock_type;

  // strap capture sequencing
  typedef enum logic [1:0] {
    SSPB_CAPTURE,
    SSPB_RUN
  } sspb_state_type;

endpackage

// [src/sspb_word.sv]
/*
  one sticky 32-bit budget word with gated write.
  assumes it is clocked by the core clock and never reset.
*/
`timescale 1ns/1ns
module sspb_word
  import sspb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  output logic      [31:0] q
);

  logic [31:0] q_r;
  logic [31:0] q_nxt;

  // hold unless enabled write
  always_comb begin
    q_nxt = we ? wdata : q_r;
  end

  // no reset: contents undefined at power-up, kept over hot reset
  always_ff @(posedge clock) begin
    q_r <= q_nxt;
  end

  assign q = q_r;

endmodule

// [src/sspb_regs.sv]
/*
  switch status and power budget data value register group.
  assumes one core clock, rst_n is the fundamental reset, hot_rst_n a
  synchronous hot reset, straps and lock state synchronous inputs.
  budget words have no reset and read unknown until software writes them.
  the register unlock bit is plain writable; no set during reset here.
*/
// Local design decision: the plain strobed port.
// Contract
// - each budget word holds one full 32-bit power budget data word
// - budget word writes accepted only while budget unlock bit is set
// - mode field reports strapped mode; 0 normal, 1 with eeprom
// - downstream common clock bit returns strap caught at fund reset
// - upstream common clock bit returns strap caught at fund reset
// - reset hold bit returns strap caught at fund reset
// - lock field shows upstream lock state, resets to zero
// - marker field resets to zero, sticky, survives hot reset
// - budget unlock bit lives in control register bit 4
// - with register unlock clear, protected fields incl. marker read-only
// - data read returns word picked by select; above 9 gives zero
`timescale 1ns/1ns
`include "sspb_params.svh"
module sspb_regs
  import sspb_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           hot_rst_n,
  input  wire sspb_req_type   req,
  output logic         [31:0] rdata,
  input  wire sspb_strap_type straps,
  input  wire logic     [2:0] upstream_lock_state,
  output logic                budget_value_unlock,
  output logic                protected_write_unlock
);

  // strap capture sequencing
  sspb_state_type state_r;
  sspb_state_type state_nxt;
  sspb_strap_type strap_r;
  sspb_strap_type strap_nxt;

  // lock mirror and sticky control fields
  logic [2:0]     lock_r;
  logic [2:0]     lock_nxt;
  logic [3:0]     marker_r;
  logic [3:0]     marker_nxt;
  logic           unl_r;
  logic           unl_nxt;
  logic           bunl_r;
  logic           bunl_nxt;

  // select and read path
  logic [7:0]     sel_r;
  logic [7:0]     sel_nxt;
  logic [31:0]    rdata_r;
  logic [31:0]    rdata_nxt;

  // budget storage and status view
  logic [31:0]    words [`SSPB_NUM_WORDS];
  logic [`SSPB_NUM_WORDS-1:0] word_we;
  logic [31:0]    status_w;

  // storage for each budget word, no reset by design
  genvar gi;
  generate
    for (gi = 0; gi < `SSPB_NUM_WORDS; gi++) begin : g_word
      sspb_word u_word (
        .clock (clock),
        .we    (word_we[gi]),
        .wdata (req.wdata),
        .q     (words[gi])
      );
    end
  endgenerate

  // write decode for budget words, gated by budget unlock
  // words have no reset, so both resets must mask writes here
  always_comb begin
    for (int i = 0; i < `SSPB_NUM_WORDS; i++) begin
      word_we[i] = req.wr && rst_n && hot_rst_n && bunl_r &&
        (req.addr == (`SSPB_OFF_BUDGET_BASE + 12'(4 * i)));
    end
  end

  // status word assembly; unused positions stay zero
  always_comb begin
    status_w = 32'h0;
    status_w[`SSPB_MODE_LSB +: 3] = strap_r.mode;
    status_w[`SSPB_CCLK_DS_BIT]   = strap_r.cclk_ds;
    status_w[`SSPB_CCLK_US_BIT]   = strap_r.cclk_us;
    status_w[`SSPB_HOLD_BIT]      = strap_r.hold;
    status_w[`SSPB_LOCK_LSB +: 3] = lock_r;
    status_w[`SSPB_MARKER_LSB +: 4] = marker_r;
  end

  // straps sampled one clock after release, not by the async path
  always_comb begin
    state_nxt = state_r;
    strap_nxt = strap_r;
    case (state_r)
      SSPB_CAPTURE: begin
        // single capture; later strap moves never reach the status
        strap_nxt = straps;
        state_nxt = SSPB_RUN;
      end
      SSPB_RUN: begin
        state_nxt = SSPB_RUN;
      end
      default: begin
        state_nxt = SSPB_CAPTURE;
      end
    endcase
  end

  // control, marker, select and lock mirror
  always_comb begin
    lock_nxt   = upstream_lock_state;
    marker_nxt = marker_r;
    unl_nxt    = unl_r;
    bunl_nxt   = bunl_r;
    sel_nxt    = sel_r;
    if (!hot_rst_n) begin
      // hot reset drops lock view and select, spares sticky bits
      lock_nxt = `SSPB_LOCK_RST;
      sel_nxt  = 8'h00;
    end else if (req.wr) begin
      case (req.addr)
        `SSPB_OFF_STATUS: begin
          // only the marker takes writes; other status bits are fixed
          if (unl_r) begin
            marker_nxt = req.wdata[`SSPB_MARKER_LSB +: 4];
          end
        end
        `SSPB_OFF_CONTROL: begin
          // register unlock is plain writable, not itself protected
          unl_nxt = req.wdata[`SSPB_CTL_UNLOCK_BIT];
          if (unl_r) begin
            bunl_nxt = req.wdata[`SSPB_CTL_BUDGET_BIT];
          end
        end
        `SSPB_OFF_SEL: begin
          sel_nxt = req.wdata[7:0];
        end
        default: begin
          sel_nxt = sel_r;
        end
      endcase
    end
  end

  // read mux, answer one cycle after strobe, zero elsewhere
  always_comb begin
    rdata_nxt = 32'h0;
    if (req.rd && hot_rst_n) begin // hot reset swallows reads
      if (req.addr == `SSPB_OFF_STATUS) begin
        rdata_nxt = status_w;
      end else if (req.addr == `SSPB_OFF_CONTROL) begin
        rdata_nxt[`SSPB_CTL_UNLOCK_BIT] = unl_r;
        rdata_nxt[`SSPB_CTL_BUDGET_BIT] = bunl_r;
      end else if (req.addr == `SSPB_OFF_SEL) begin
        rdata_nxt[7:0] = sel_r;
      end else if (req.addr == `SSPB_OFF_BUDGET_DATA) begin
        // select past the last word answers zero
        if (sel_r <= `SSPB_SEL_MAX) begin
          rdata_nxt = words[sel_r[3:0]];
        end
      end else begin
        // direct word window, readable whatever the unlock state
        for (int i = 0; i < `SSPB_NUM_WORDS; i++) begin
          if (req.addr == (`SSPB_OFF_BUDGET_BASE + 12'(4 * i))) begin
            rdata_nxt = words[i];
          end
        end
      end
    end
  end

  // strap group: fundamental reset only, hot reset has no effect
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= SSPB_CAPTURE;
      strap_r <= '0;
    end else begin
      state_r <= state_nxt;
      strap_r <= strap_nxt;
    end
  end

  // control group: sticky bits cleared by fundamental reset only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_r   <= `SSPB_LOCK_RST;
      marker_r <= `SSPB_MARKER_RST;
      unl_r    <= 1'b0;
      bunl_r   <= 1'b0;
      sel_r    <= 8'h00;
    end else begin
      lock_r   <= lock_nxt;
      marker_r <= marker_nxt;
      unl_r    <= unl_nxt;
      bunl_r   <= bunl_nxt;
      sel_r    <= sel_nxt;
    end
  end

  // read register: zero outside the answer cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs straight from their flops
  assign rdata                  = rdata_r;
  assign budget_value_unlock    = bunl_r;
  assign protected_write_unlock = unl_r;

endmodule

// [tb/sspb_monitor.sv]
/*
  concurrent checks on the status and budget register group ports.
  assumes one core clock and rst_n as the fundamental reset.
*/
`timescale 1ns/1ns
module sspb_monitor
  import sspb_pkg::*;
(
  input wire logic           clock,
  input wire logic           rst_n,
  input wire logic           hot_rst_n,
  input wire sspb_req_type   req,
  input wire logic    [31:0] rdata,
  input wire sspb_strap_type straps,
  input wire logic     [2:0] upstream_lock_state,
  input wire logic           budget_value_unlock,
  input wire logic           protected_write_unlock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // taken control write; hot reset swallows requests
  wire ctl_w = req.wr && req.addr == 12'h32C && hot_rst_n;
  sequence st_rd;
    req.rd && req.addr == 12'h328 && hot_rst_n;
  endsequence
  rdata_idle_a: assert property (rdata != 32'h0 |-> $past(req.rd))
    else $error("read data without a read");
  status_resv_a: assert property (st_rd |=>
    (rdata & 32'h0F8FFD98) == 32'h0) else $error("reserved bit set");
  // lock code passes a mirror flop, then the read flop
  lock_view_a: assert property (st_rd ##0 $past(hot_rst_n && rst_n)
    |=> rdata[22:20] == $past(upstream_lock_state, 2))
    else $error("lock field wrong");
  strap_keep_a: assert property (st_rd ##0 $past(rst_n, 2) ##1 st_rd
    |=> $stable(rdata[9:0])) else $error("strap bits moved");
  unlock_gate_a: assert property ($changed(budget_value_unlock) |->
    $past(ctl_w && protected_write_unlock)) else $error("locked change");
  unlock_set_a: assert property (ctl_w && protected_write_unlock |=>
    budget_value_unlock == $past(req.wdata[4])) else $error("budget bit");
  reg_unlock_a: assert property (ctl_w |=>
    protected_write_unlock == $past(req.wdata[3])) else $error("unlock bit");
  hot_keep_a: assert property (!hot_rst_n |=>
    $stable(budget_value_unlock)) else $error("unlock lost in hot reset");
endmodule

bind sspb_regs sspb_monitor mon_u (.clock, .rst_n, .hot_rst_n, .req, .rdata,
  .straps, .upstream_lock_state, .budget_value_unlock,
  .protected_write_unlock);

// [tb/tb_top.sv]
/*
  self-checking bench for the status and budget register group.
  assumes sspb_regs and its bound checker are compiled before it.
*/
`timescale 1ns/1ns
module tb_top
  import sspb_pkg::*;
;
  logic           clock = 1'b0;
  logic           rst_n = 1'b0;
  logic           hot_rst_n = 1'b1;
  logic           pend = 1'b0;
  sspb_req_type   req = '0;
  sspb_strap_type straps = '0;
  sspb_strap_type cap;
  logic     [2:0] lock = 3'h0;
  logic    [31:0] rdata;
  logic    [31:0] d;
  logic    [31:0] bw [10];
  logic    [31:0] expq [$];
  int             miscompares = 0;
  int             n_compared = 0;
  int             seed;
  int             cyc = 0;

  sspb_regs dut_u (.clock, .rst_n, .hot_rst_n, .req, .rdata, .straps,
    .upstream_lock_state(lock), .budget_value_unlock(),
    .protected_write_unlock());

  initial begin
    forever #50 clock = ~clock;
  end

  task automatic summarize;
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one request per call; strobes held so calls run back to back
  task automatic op(input logic r, input logic [11:0] a,
                    input logic [31:0] v);
    req <= '{addr: a, wdata: v, wr: !r, rd: r};
    if (r) expq.push_back(v);
    @(posedge clock);
  endtask

  task automatic idle(input int n);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  function automatic logic [31:0] st(input logic [3:0] m,
                                     input logic [2:0] l);
    return {m, 5'h00, l, 10'h000, cap.hold, 2'h0, cap.cclk_us,
            cap.cclk_ds, 2'h0, cap.mode};
  endfunction

  // note taken at the read edge, compared half a cycle later
  always @(posedge clock) pend <= req.rd && rst_n && hot_rst_n;
  always @(negedge clock) begin
    if (pend) begin
      d = expq.pop_front();
      n_compared++;
      if (rdata !== d) begin
        miscompares++;
        $display("wrong value %0t: got %h want %h", $time, rdata, d);
      end
    end
  end

  // hang guard, well past two rounds of traffic
  always @(posedge clock) begin
    cyc++;
    if (cyc > 1500) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    seed = 32'h4E0882FB;
    for (int r = 0; r < 2; r++) begin
      req <= '0;
      lock <= 3'h0; // status reads after reset expect an idle lock
      rst_n <= 1'b0;
      d = $random(seed);
      cap = {r[2:0], d[2:0]};
      straps <= cap;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      idle(1);
      straps <= ~cap; // straps move after capture; status must not
      idle(1);
      op(1, 12'h328, st(4'h0, 3'h0));
      op(1, 12'h328, st(4'h0, 3'h0));
      op(0, 12'h32C, 32'h10);
      op(1, 12'h32C, 32'h0);
      op(0, 12'h32C, 32'h8);
      op(0, 12'h32C, 32'h18);
      op(1, 12'h32C, 32'h18);
      for (int i = 0; i < 10; i++) begin
        bw[i] = $random(seed);
        op(0, 12'h300 + 12'(4 * i), bw[i]);
      end
      for (int i = 0; i < 11; i++) begin
        op(0, 12'h284, 32'(i));
        op(1, 12'h288, (i < 10) ? bw[i] : 32'h0);
        if (i < 10) op(1, 12'h300 + 12'(4 * i), bw[i]);
      end
      op(0, 12'h32C, 32'h8);
      op(0, 12'h300, ~bw[0]);
      op(1, 12'h300, bw[0]);
      op(0, 12'h328, 32'hFFFFFFFF);
      for (int k = 1; k < 5; k++) begin
        lock <= (k == 1) ? 3'h0 : 3'(k);
        idle(2);
        op(1, 12'h328, st(4'hF, lock));
      end
      hot_rst_n <= 1'b0;
      idle(2);
      hot_rst_n <= 1'b1;
      idle(1);
      op(1, 12'h288, bw[0]);
      op(1, 12'h328, st(4'hF, lock));
      op(0, 12'h32C, 32'h10);
      op(0, 12'h328, 32'h0);
      op(0, 12'h32C, 32'h0);
      op(1, 12'h328, st(4'hF, lock));
      op(1, 12'h32C, 32'h10);
      op(0, 12'h300, ~bw[0]);
      op(1, 12'h300, ~bw[0]);
      idle(2);
    end
    summarize();
  end
endmodule
